// file: core/slk_map.svh
`ifndef SLK_MAP_SVH
`define SLK_MAP_SVH
// Capability advert layout: 4-bit bitmap, four 5-bit subfields
`define SLK_ALG_SC     0
`define SLK_ALG_AES    1
`define SLK_SUB_W      5
`define SLK_SC_LSB     0
`define SLK_AES_LSB    5
`define SLK_SC_ADD     6'h04
`define SLK_AES_128    2'h1
`define SLK_AES_192    2'h2
`define SLK_AES_256    2'h3
`define SLK_AES_OFB    3'h1
// Key lengths in bytes
`define SLK_KEY_16     6'h10
`define SLK_KEY_24     6'h18
`define SLK_KEY_32     6'h20
`define SLK_SC_MIN     6'h05
// Shared secret, key and vector positions
`define SLK_SS_W       326
`define SLK_KEY_W      280
`define SLK_KEY_BYTES  35
`define SLK_IV_LSB     256
// Burst limits in bits, CRC included
`define SLK_UL_MAX     12'h03E8
`define SLK_DL_MAX     12'h09EB
`define SLK_CRC_BITS   12'h0010
`define SLK_CRC_POLY   16'h1021
`define SLK_CRC_INIT   16'hFFFF
`endif

// file: core/slk_pkg.sv
`include "slk_map.svh"
package slk_pkg;
	typedef enum logic [1:0] {cs_idle, cs_skip, cs_data, cs_crc}
		slk_cod_st_t;

	typedef struct packed {
		logic       sc_en;
		logic [5:0] sc_max;
		logic       aes_en;
		logic [5:0] aes_max;
		logic       bad;
	} slk_caps_t;

	// Subfields are sent LSB first, so list element i is bit i
	function automatic slk_caps_t slk_decode(input logic [3:0] alg,
		input logic [19:0] par);
		slk_caps_t  c;
		logic [4:0] sc;
		logic [4:0] ae;
		sc = par[`SLK_SC_LSB +: `SLK_SUB_W];
		ae = par[`SLK_AES_LSB +: `SLK_SUB_W];
		c.sc_en  = alg[`SLK_ALG_SC] && (sc != 5'h00);
		c.sc_max = c.sc_en ? ({1'b0, sc} + `SLK_SC_ADD) : 6'h00;
		case (ae[1:0])
			`SLK_AES_128: c.aes_max = `SLK_KEY_16;
			`SLK_AES_192: c.aes_max = `SLK_KEY_24;
			`SLK_AES_256: c.aes_max = `SLK_KEY_32;
			default:      c.aes_max = 6'h00;
		endcase
		c.aes_en = alg[`SLK_ALG_AES] && (ae[1:0] != 2'h0)
			&& (ae[4:2] == `SLK_AES_OFB);
		c.bad = (alg[`SLK_ALG_SC] != (sc != 5'h00))
			|| (alg[`SLK_ALG_AES] != (ae[1:0] != 2'h0))
			|| ((ae[1:0] == 2'h0) && (ae[4:2] != 3'h0))
			|| ((ae[1:0] != 2'h0) && (ae[4:2] != `SLK_AES_OFB))
			|| (par[19:10] != 10'h000) || (alg[3:2] != 2'h0);
		return c;
	endfunction

	// Legal request: AES 16/24/32 up to the advert, else 5..max
	function automatic logic slk_len_ok(input slk_caps_t c,
		input logic aes, input logic [5:0] n);
		if (aes)
			return c.aes_en && (n <= c.aes_max) && ((n == `SLK_KEY_16)
				|| (n == `SLK_KEY_24) || (n == `SLK_KEY_32));
		return c.sc_en && (n >= `SLK_SC_MIN) && (n <= c.sc_max);
	endfunction

	// Keep the n low bytes of the secret, zero the rest
	function automatic logic [`SLK_KEY_W-1:0] slk_key_sel(
		input logic [`SLK_SS_W-1:0] ss, input logic [5:0] n);
		logic [`SLK_KEY_W-1:0] k;
		k = '0;
		for (int i = 0; i < `SLK_KEY_BYTES; i++)
			if (6'(i) < n)
				k[i*8 +: 8] = ss[i*8 +: 8];
		return k;
	endfunction

	// Four copies of secret bits 256..287 mixed with the stream vector
	function automatic logic [127:0] slk_iv(
		input logic [`SLK_SS_W-1:0] ss, input logic [31:0] iv);
		return {4{ss[`SLK_IV_LSB +: 32] ^ iv}};
	endfunction
endpackage

// file: core/slk_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface slk_link_if;
	// Capability advert from the base station
	logic [3:0]  cap_alg;
	logic [19:0] cap_par;
	// Downlink burst bits
	logic        dl_valid;
	logic        dl_bit;
	logic        dl_last;
	// Uplink burst bits
	logic        ul_valid;
	logic        ul_bit;
	logic        ul_last;

	modport base (output cap_alg, cap_par, dl_valid, dl_bit, dl_last,
		input ul_valid, ul_bit, ul_last);
	modport term (input cap_alg, cap_par, dl_valid, dl_bit, dl_last,
		output ul_valid, ul_bit, ul_last);
endinterface
`default_nettype wire

// file: core/slk_codec.sv
`timescale 1ns/1ps
`default_nettype none
`include "slk_map.svh"
module slk_codec (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// High for a receiver
	input  wire logic        rx_mode,
	// Burst setup
	input  wire logic        start,
	input  wire logic [11:0] len,
	input  wire logic [11:0] ks_len,
	// Incoming bits and keystream
	input  wire logic        in_valid,
	input  wire logic        in_bit,
	input  wire logic        ks_valid,
	input  wire logic        ks_bit,
	// Outgoing bits and status
	output logic             out_valid,
	output logic             out_bit,
	output logic             out_last,
	output logic             done,
	output logic             crc_bad,
	output logic             busy
);
	slk_pkg::slk_cod_st_t state_q;
	logic [11:0]          skip_q;
	logic [11:0]          cnt_q;
	logic                 has_data_q;
	logic [15:0]          crc_q;
	logic                 bad_q;
	logic                 cipher;
	logic                 step;
	logic                 crc_step;
	logic [15:0]          crc_d;

	// The CRC always sees ciphertext, whichever way bits flow
	assign cipher = rx_mode ? in_bit : (in_bit ^ ks_bit); // see R14, R15
	assign step = in_valid && ks_valid;
	assign crc_step = !rx_mode || in_valid;
	assign busy = (state_q != slk_pkg::cs_idle);
	assign crc_d = {crc_q[14:0], 1'b0}
		^ ((crc_q[15] ^ cipher) ? `SLK_CRC_POLY : 16'h0000);

	// Burst sequencer: skip spare keystream, cipher bits, then CRC
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_q <= slk_pkg::cs_idle;
			skip_q <= 12'h000;
			cnt_q <= 12'h000;
			has_data_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				slk_pkg::cs_idle:
					if (start)
					begin
						skip_q <= ks_len - len; // see R16, R17, R18
						has_data_q <= (len != 12'h000);
						cnt_q <= (len != 12'h000) ? len : `SLK_CRC_BITS;
						if (ks_len != len)
							state_q <= slk_pkg::cs_skip;
						else if (len != 12'h000)
							state_q <= slk_pkg::cs_data;
						else
							state_q <= slk_pkg::cs_crc;
					end
				slk_pkg::cs_skip:
					if (ks_valid)
					begin
						skip_q <= skip_q - 12'h001; // leading bits dropped
						if (skip_q == 12'h001)
							state_q <= has_data_q ? slk_pkg::cs_data
								: slk_pkg::cs_crc;
					end
				slk_pkg::cs_data:
					if (step)
					begin
						cnt_q <= cnt_q - 12'h001;
						if (cnt_q == 12'h001)
						begin
							state_q <= slk_pkg::cs_crc;
							cnt_q <= `SLK_CRC_BITS;
						end
					end
				slk_pkg::cs_crc:
					if (crc_step)
					begin
						cnt_q <= cnt_q - 12'h001;
						if (cnt_q == 12'h001)
							state_q <= slk_pkg::cs_idle;
					end
				default: state_q <= slk_pkg::cs_idle;
			endcase
		end
	end

	// Data path: XOR with keystream, CRC sent or checked in clear
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			crc_q <= `SLK_CRC_INIT;
			bad_q <= 1'b0;
			out_valid <= 1'b0;
			out_bit <= 1'b0;
			out_last <= 1'b0;
			done <= 1'b0;
			crc_bad <= 1'b0;
		end
		else
		begin
			out_valid <= 1'b0;
			out_last <= 1'b0;
			done <= 1'b0;
			crc_bad <= 1'b0;
			if (state_q == slk_pkg::cs_idle && start)
			begin
				crc_q <= `SLK_CRC_INIT;
				bad_q <= 1'b0;
			end
			else if (state_q == slk_pkg::cs_data && step)
			begin
				crc_q <= crc_d;
				out_valid <= 1'b1;
				out_bit <= in_bit ^ ks_bit; // see R13, R15
			end
			else if (state_q == slk_pkg::cs_crc && crc_step)
			begin
				crc_q <= {crc_q[14:0], 1'b0};
				if (rx_mode)
					bad_q <= bad_q | (in_bit != crc_q[15]); // see R15
				else
				begin
					out_valid <= 1'b1;
					out_bit <= crc_q[15]; // see R11, R12, R14
					out_last <= (cnt_q == 12'h001);
				end
				if (cnt_q == 12'h001)
				begin
					done <= 1'b1;
					crc_bad <= rx_mode && (bad_q | (in_bit != crc_q[15]));
				end
			end
		end
	end
endmodule // slk_codec
`default_nettype wire

// file: core/slk_base_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "slk_map.svh"
// Function
// R1: Nonzero stream subfield: max key bytes plus four
// R2: Zero stream subfield disables the stream cipher
// R3: AES bits 01/10/11 give 128/192/256, 00 off
// R4: AES mode 001 is OFB, 000 when off
// R5: Both ends support AES and stream cipher
// R6: Key is low key-length bytes of secret
// R7: Stream key at most 35 bytes
// R8: AES key 16/24/32 bytes, bits 256-287 vector
// R9: Base ends streams or registration at limits
// R10: Terminal closes streams or re-registers at limits
// R11: Uplink burst at most 1000 bits, CRC clear
// R12: Downlink burst at most 2539 bits, CRC clear
// R13: Header and payload XORed with keystream
// R14: CRC computed over ciphertext, sent in clear
// R15: Receiver checks CRC, then decrypts by XOR; here each bit is decrypted as it arrives, before the CRC check ends
// R16: Basic header: last payload bit ends keystream
// R17: Minimized header aligns likewise; spare keystream dropped
// R18: 28-bit header packed behind four zero bits
// R19: AES starts from key and per-stream vector
// R20: Word bit n is secret bit n+256
// R21: Word XORed with the stream-cipher vector
// R22: AES vector is four copies of word
// R23: Algorithm bitmap: bit0 stream, bit1 AES
// R24: Four 5-bit subfields, unsupported ones zero
module slk_base_end (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst,
	// Radio link
	slk_link_if.base                link,
	// Capability advert sent to terminals
	input  wire logic [3:0]         adv_alg,
	input  wire logic [19:0]        adv_par,
	// Shared secret and stream control
	input  wire logic [325:0]       secret,
	input  wire logic               secret_load,
	input  wire logic               stream_start,
	input  wire logic [31:0]        stream_iv,
	input  wire logic               use_aes,
	input  wire logic [5:0]         key_len_req,
	// Limits, zero disables
	input  wire logic [15:0]        base_registration_limit,
	input  wire logic [15:0]        base_burst_limit,
	// Downlink transmit
	input  wire logic               tx_start,
	input  wire logic [11:0]        tx_len,
	input  wire logic [11:0]        tx_ks_len,
	input  wire logic               tx_valid,
	input  wire logic               tx_bit,
	input  wire logic               tx_ks_valid,
	input  wire logic               tx_ks_bit,
	// Uplink receive
	input  wire logic               rx_start,
	input  wire logic [11:0]        rx_len,
	input  wire logic [11:0]        rx_ks_len,
	input  wire logic               rx_ks_valid,
	input  wire logic               rx_ks_bit,
	output logic                    rx_valid,
	output logic                    rx_bit,
	output logic                    rx_done,
	output logic                    rx_crc_bad,
	// Key material
	output logic [279:0]            key,
	output logic [5:0]              key_len,
	output logic                    key_aes,
	output logic [127:0]            block_cipher_init_vector,
	// Status
	output logic                    cfg_err,
	output logic                    key_err,
	output logic                    len_err,
	output logic                    stream_open,
	output logic                    stream_close,
	output logic                    reg_close
);
	slk_pkg::slk_caps_t caps;
	logic               len_ok;
	logic               stream_go;
	logic               tx_go;
	logic               rx_go;
	logic               tx_busy;
	logic               rx_busy;
	logic               tx_done;
	logic               reg_full_q;
	logic [15:0]        burst_cnt_q;
	logic [15:0]        reg_cnt_q;
	logic [15:0]        burst_nxt;
	logic [15:0]        reg_nxt;

	// Own advert decoded the same way a terminal will read it
	assign caps = slk_pkg::slk_decode(adv_alg,
		adv_par); // see R1, R2, R3, R4, R23
	assign len_ok = slk_pkg::slk_len_ok(caps, use_aes,
		key_len_req); // see R5, R7, R8
	// A full registration refuses new streams until a new secret
	assign stream_go = stream_start && len_ok && !caps.bad
		&& !reg_full_q && !secret_load; // see R9
	// Length checks leave room for the 16 clear CRC bits
	assign tx_go = tx_start && !tx_busy && stream_open
		&& (tx_len <= `SLK_DL_MAX - `SLK_CRC_BITS)
		&& (tx_ks_len >= tx_len); // see R12
	assign rx_go = rx_start && !rx_busy
		&& (rx_len <= `SLK_UL_MAX - `SLK_CRC_BITS)
		&& (rx_ks_len >= rx_len); // see R11
	assign burst_nxt = burst_cnt_q + 16'h0001;
	assign reg_nxt = reg_cnt_q + 16'h0001;

	// Advert flops onto the link so it is stable for the terminal
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			link.cap_alg <= 4'h0;
			link.cap_par <= 20'h0_0000;
			cfg_err <= 1'b0;
		end
		else
		begin
			link.cap_alg <= adv_alg; // see R23
			link.cap_par <= adv_par; // see R24
			cfg_err <= caps.bad; // see R24
		end
	end

	// Key and vector latch at stream start; old ones kept otherwise
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			key <= '0;
			key_len <= 6'h00;
			key_aes <= 1'b0;
			block_cipher_init_vector <= '0;
			key_err <= 1'b0;
		end
		else
		begin
			key_err <= stream_start && !stream_go; // see R9
			if (stream_go)
			begin
				key <= slk_pkg::slk_key_sel(secret,
					key_len_req); // see R6, R7, R8
				key_len <= key_len_req;
				key_aes <= use_aes; // see R19
				block_cipher_init_vector <= slk_pkg::slk_iv(secret,
					stream_iv); // see R20, R21, R22
			end
		end
	end

	// Stream and registration counters against the base limits
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			burst_cnt_q <= 16'h0000;
			reg_cnt_q <= 16'h0000;
			reg_full_q <= 1'b0;
			stream_open <= 1'b0;
			stream_close <= 1'b0;
			reg_close <= 1'b0;
		end
		else
		begin
			stream_close <= 1'b0;
			reg_close <= 1'b0;
			if (secret_load)
			begin
				reg_cnt_q <= 16'h0000;
				reg_full_q <= 1'b0;
				stream_open <= 1'b0;
			end
			else if (stream_go)
			begin
				reg_cnt_q <= reg_nxt;
				burst_cnt_q <= 16'h0000;
				stream_open <= 1'b1;
				if (base_registration_limit != 16'h0000
					&& reg_nxt == base_registration_limit)
				begin
					reg_full_q <= 1'b1; // see R9
					reg_close <= 1'b1;
				end
			end
			else if (tx_done)
			begin
				burst_cnt_q <= burst_nxt;
				if (base_burst_limit != 16'h0000
					&& burst_nxt == base_burst_limit)
				begin
					stream_open <= 1'b0; // see R9
					stream_close <= 1'b1;
				end
			end
		end
	end

	// Refused burst starts are reported, never queued
	always_ff @(posedge core_clk)
	begin
		if (rst)
			len_err <= 1'b0;
		else
			len_err <= (tx_start && !tx_go) || (rx_start && !rx_go);
	end

	// Downlink encoder
	slk_codec u_tx (
		.core_clk  (core_clk),
		.rst       (rst),
		.rx_mode   (1'b0),
		.start     (tx_go),
		.len       (tx_len),
		.ks_len    (tx_ks_len),
		.in_valid  (tx_valid),
		.in_bit    (tx_bit),
		.ks_valid  (tx_ks_valid),
		.ks_bit    (tx_ks_bit),
		.out_valid (link.dl_valid),
		.out_bit   (link.dl_bit),
		.out_last  (link.dl_last),
		.done      (tx_done),
		.crc_bad   (),
		.busy      (tx_busy)
	);

	// Uplink decoder
	slk_codec u_rx (
		.core_clk  (core_clk),
		.rst       (rst),
		.rx_mode   (1'b1),
		.start     (rx_go),
		.len       (rx_len),
		.ks_len    (rx_ks_len),
		.in_valid  (link.ul_valid),
		.in_bit    (link.ul_bit),
		.ks_valid  (rx_ks_valid),
		.ks_bit    (rx_ks_bit),
		.out_valid (rx_valid),
		.out_bit   (rx_bit),
		.out_last  (),
		.done      (rx_done),
		.crc_bad   (rx_crc_bad),
		.busy      (rx_busy)
	);
endmodule // slk_base_end
`default_nettype wire

// file: core/slk_term_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "slk_map.svh"
module slk_term_end (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst,
	// Radio link
	slk_link_if.term                link,
	// Shared secret and stream control
	input  wire logic [325:0]       secret,
	input  wire logic               secret_load,
	input  wire logic               stream_start,
	input  wire logic [31:0]        stream_iv,
	input  wire logic               use_aes,
	input  wire logic [5:0]         key_len_req,
	// Limits, zero disables
	input  wire logic [15:0]        terminal_registration_limit,
	input  wire logic [15:0]        terminal_burst_limit,
	// Uplink transmit
	input  wire logic               tx_start,
	input  wire logic [11:0]        tx_len,
	input  wire logic [11:0]        tx_ks_len,
	input  wire logic               tx_valid,
	input  wire logic               tx_bit,
	input  wire logic               tx_ks_valid,
	input  wire logic               tx_ks_bit,
	// Downlink receive
	input  wire logic               rx_start,
	input  wire logic [11:0]        rx_len,
	input  wire logic [11:0]        rx_ks_len,
	input  wire logic               rx_ks_valid,
	input  wire logic               rx_ks_bit,
	output logic                    rx_valid,
	output logic                    rx_bit,
	output logic                    rx_done,
	output logic                    rx_crc_bad,
	// Key material
	output logic [279:0]            key,
	output logic [127:0]            block_cipher_init_vector,
	// Status
	output logic                    cfg_err,
	output logic                    key_err,
	output logic                    len_err,
	output logic                    stream_open,
	output logic                    close_req,
	output logic                    renew_req
);
	slk_pkg::slk_caps_t caps;
	logic               len_ok;
	logic               stream_go;
	logic               tx_go;
	logic               rx_go;
	logic               tx_busy;
	logic               rx_busy;
	logic               tx_done;
	logic [15:0]        burst_cnt_q;
	logic [15:0]        reg_cnt_q;
	logic [15:0]        burst_nxt;
	logic [15:0]        reg_nxt;

	// Terminal reads the base advert off the link
	assign caps = slk_pkg::slk_decode(link.cap_alg, link.cap_par);
	assign len_ok = slk_pkg::slk_len_ok(caps, use_aes, key_len_req);
	assign stream_go = stream_start && len_ok && !caps.bad && !secret_load;
	assign tx_go = tx_start && !tx_busy && stream_open
		&& (tx_len <= `SLK_UL_MAX - `SLK_CRC_BITS)
		&& (tx_ks_len >= tx_len); // see R11
	assign rx_go = rx_start && !rx_busy
		&& (rx_len <= `SLK_DL_MAX - `SLK_CRC_BITS)
		&& (rx_ks_len >= rx_len); // see R12
	assign burst_nxt = burst_cnt_q + 16'h0001;
	assign reg_nxt = reg_cnt_q + 16'h0001;

	// Key, vector and error flags
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			key <= '0;
			block_cipher_init_vector <= '0;
			cfg_err <= 1'b0;
			key_err <= 1'b0;
			len_err <= 1'b0;
		end
		else
		begin
			cfg_err <= caps.bad; // see R24
			key_err <= stream_start && !stream_go;
			len_err <= (tx_start && !tx_go) || (rx_start && !rx_go);
			if (stream_go)
			begin
				key <= slk_pkg::slk_key_sel(secret, key_len_req); // see R6
				block_cipher_init_vector <= slk_pkg::slk_iv(secret,
					stream_iv); // see R19, R22
			end
		end
	end

	// Terminal asks its own side to close or re-register gracefully
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			burst_cnt_q <= 16'h0000;
			reg_cnt_q <= 16'h0000;
			stream_open <= 1'b0;
			close_req <= 1'b0;
			renew_req <= 1'b0;
		end
		else
		begin
			close_req <= 1'b0;
			renew_req <= 1'b0;
			if (secret_load)
			begin
				reg_cnt_q <= 16'h0000;
				stream_open <= 1'b0;
			end
			else if (stream_go)
			begin
				reg_cnt_q <= reg_nxt;
				burst_cnt_q <= 16'h0000;
				stream_open <= 1'b1;
				renew_req <= terminal_registration_limit != 16'h0000
					&& reg_nxt == terminal_registration_limit; // see R10
			end
			else if (tx_done)
			begin
				burst_cnt_q <= burst_nxt;
				if (terminal_burst_limit != 16'h0000
					&& burst_nxt == terminal_burst_limit)
				begin
					stream_open <= 1'b0; // see R10
					close_req <= 1'b1;
				end
			end
		end
	end

	// Uplink encoder
	slk_codec u_tx (
		.core_clk  (core_clk),
		.rst       (rst),
		.rx_mode   (1'b0),
		.start     (tx_go),
		.len       (tx_len),
		.ks_len    (tx_ks_len),
		.in_valid  (tx_valid),
		.in_bit    (tx_bit),
		.ks_valid  (tx_ks_valid),
		.ks_bit    (tx_ks_bit),
		.out_valid (link.ul_valid),
		.out_bit   (link.ul_bit),
		.out_last  (link.ul_last),
		.done      (tx_done),
		.crc_bad   (),
		.busy      (tx_busy)
	);

	// Downlink decoder
	slk_codec u_rx (
		.core_clk  (core_clk),
		.rst       (rst),
		.rx_mode   (1'b1),
		.start     (rx_go),
		.len       (rx_len),
		.ks_len    (rx_ks_len),
		.in_valid  (link.dl_valid),
		.in_bit    (link.dl_bit),
		.ks_valid  (rx_ks_valid),
		.ks_bit    (rx_ks_bit),
		.out_valid (rx_valid),
		.out_bit   (rx_bit),
		.out_last  (),
		.done      (rx_done),
		.crc_bad   (rx_crc_bad),
		.busy      (rx_busy)
	);
endmodule // slk_term_end
`default_nettype wire

// file: bench/slk_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "slk_map.svh"
module slk_chk (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Burst lines of the link
	input  wire logic dl_valid,
	input  wire logic dl_bit,
	input  wire logic dl_last,
	input  wire logic ul_valid,
	input  wire logic ul_bit,
	input  wire logic ul_last
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	logic [15:0] dc_q, uc_q;
	logic [11:0] dn_q, un_q;

	// Shifting the sent CRC in as well leaves a zero residue
	function automatic logic [15:0] nx(input logic [15:0] c,
		input logic b, input logic v);
		return v ? {c[14:0], 1'b0} ^ (c[15] ^ b ? `SLK_CRC_POLY : 16'h0000) : c;
	endfunction

	// Running CRC and bit count per direction, restarted after last
	always_ff @(posedge core_clk)
	begin
		dc_q <= (rst || dl_last) ? `SLK_CRC_INIT : nx(dc_q, dl_bit, dl_valid);
		dn_q <= (rst || dl_last) ? 12'h000 : dn_q + {11'h000, dl_valid};
		uc_q <= (rst || ul_last) ? `SLK_CRC_INIT : nx(uc_q, ul_bit, ul_valid);
		un_q <= (rst || ul_last) ? 12'h000 : un_q + {11'h000, ul_valid};
	end

	// A frame must leave the line idle before the next can begin
	sequence quiet2(v);
		!v [*2];
	endsequence
	dl_last_a: assert property (dl_last |-> dl_valid)
		else $error("downlink last without valid");
	ul_last_a: assert property (ul_last |-> ul_valid)
		else $error("uplink last without valid");
	dl_gap_a: assert property (dl_last |=> quiet2(dl_valid))
		else $error("downlink bits run on past last");
	ul_gap_a: assert property (ul_last |=> quiet2(ul_valid))
		else $error("uplink bits run on past last");
	dl_crc_a: assert property (dl_last |-> !nx(dc_q, dl_bit, 1'b1))
		else $error("downlink CRC wrong");
	ul_crc_a: assert property (ul_last |-> !nx(uc_q, ul_bit, 1'b1))
		else $error("uplink CRC wrong");
	dl_len_a: assert property (dl_valid |-> dn_q < `SLK_DL_MAX)
		else $error("downlink burst too long");
	ul_len_a: assert property (ul_valid |-> un_q < `SLK_UL_MAX)
		else $error("uplink burst too long");
endmodule // slk_chk
`default_nettype wire

// file: bench/tb_secure_link_key_iv_and_burst_xor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_secure_link_key_iv_and_burst_xor;
	// Shared stream control, advert and limits
	logic         core_clk, rst, secret_load, stream_start, use_aes;
	logic [325:0] secret;
	logic [31:0]  stream_iv;
	logic [5:0]   key_len_req, b_kl;
	logic [3:0]   adv_alg;
	logic [19:0]  adv_par;
	logic [15:0]  brl, bbl, trl, tbl;
	// Bench sender, steered to either end by up
	logic         up, s_start, s_v, s_b, s_kv, s_kb, r_start, r_kv, r_kb;
	logic [11:0]  s_len, s_kl;
	// Outputs of both ends
	logic         b_rv, b_rb, b_rd, b_rc, b_ka, b_ce, b_ke, b_le, b_so, b_sc;
	logic         b_rg, t_rv, t_rb, t_rd, t_rc, t_ce, t_ke, t_le, t_so, t_cr;
	logic [279:0] b_key, t_key;
	logic [127:0] b_iv, t_iv;
	logic [9:0]   seen;
	logic         t_rn, wq[$], rq[$];
	int           bad_count, tests_run, cyc;

	slk_link_if link ();
	slk_base_end u_slk_base_end (.core_clk, .rst, .link, .adv_alg, .adv_par,
		.secret, .secret_load, .stream_start, .stream_iv, .use_aes,
		.key_len_req, .base_registration_limit(brl), .base_burst_limit(bbl),
		.tx_start(s_start & ~up), .tx_len(s_len), .tx_ks_len(s_kl),
		.tx_valid(s_v & ~up), .tx_bit(s_b), .tx_ks_valid(s_kv & ~up),
		.tx_ks_bit(s_kb), .rx_start(r_start & up), .rx_len(s_len),
		.rx_ks_len(s_kl), .rx_ks_valid(r_kv & up), .rx_ks_bit(r_kb),
		.rx_valid(b_rv), .rx_bit(b_rb), .rx_done(b_rd), .rx_crc_bad(b_rc),
		.key(b_key), .key_len(b_kl), .key_aes(b_ka),
		.block_cipher_init_vector(b_iv), .cfg_err(b_ce), .key_err(b_ke),
		.len_err(b_le), .stream_open(b_so), .stream_close(b_sc),
		.reg_close(b_rg));
	slk_term_end u_slk_term_end (.core_clk, .rst, .link, .secret,
		.secret_load, .stream_start, .stream_iv, .use_aes, .key_len_req,
		.terminal_registration_limit(trl), .terminal_burst_limit(tbl),
		.tx_start(s_start & up), .tx_len(s_len), .tx_ks_len(s_kl),
		.tx_valid(s_v & up), .tx_bit(s_b), .tx_ks_valid(s_kv & up),
		.tx_ks_bit(s_kb), .rx_start(r_start & ~up), .rx_len(s_len),
		.rx_ks_len(s_kl), .rx_ks_valid(r_kv & ~up), .rx_ks_bit(r_kb),
		.rx_valid(t_rv), .rx_bit(t_rb), .rx_done(t_rd), .rx_crc_bad(t_rc),
		.key(t_key), .block_cipher_init_vector(t_iv), .cfg_err(t_ce),
		.key_err(t_ke), .len_err(t_le), .stream_open(t_so),
		.close_req(t_cr), .renew_req(t_rn));
	slk_chk u_slk_chk (.core_clk, .rst, .dl_valid(link.dl_valid),
		.dl_bit(link.dl_bit), .dl_last(link.dl_last),
		.ul_valid(link.ul_valid), .ul_bit(link.ul_bit),
		.ul_last(link.ul_last));

	// Clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Receive keystream lags one cycle so it meets the link bits
	always @(posedge core_clk)
	begin
		r_start <= s_start;
		r_kv <= s_kv;
		r_kb <= s_kb;
		seen = seen | {t_rn, b_rg, b_rc | t_rc, b_rd | t_rd, t_cr, b_sc, t_le,
			b_le, t_ke, b_ke};
		if (up ? link.ul_valid : link.dl_valid)
			wq.push_back(up ? link.ul_bit : link.dl_bit);
		if (up ? b_rv : t_rv)
			rq.push_back(up ? b_rb : t_rb);
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			give_verdict();
		end
	end

	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask
	function automatic logic pat(input int i);
		return ((i * 5) % 7) < 3;
	endfunction

	function automatic logic [279:0] km(input int n);
		return secret[279:0] & ((280'h1 << (8 * n)) - 280'h1);
	endfunction

	task automatic chk(input string w, input logic [279:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", w, e, g);
		end
	endtask

	// Pulses clear seen first, so it holds only this request's answers
	task automatic go(input logic a, input logic [5:0] n);
		use_aes = a;
		key_len_req = n;
		stream_start = 1'b1;
		seen = '0;
		tick;
		stream_start = 1'b0;
		repeat (3) tick;
	endtask

	task automatic adv(input logic [3:0] a, input logic [4:0] e, s);
		adv_alg = a;
		adv_par = {10'h000, e, s};
		repeat (3) tick;
	endtask

	task automatic start(input logic u, input logic [11:0] n, k);
		up = u;
		s_len = n;
		s_kl = k;
		s_start = 1'b1;
		seen = '0;
		wq.delete();
		rq.delete();
		tick;
		s_start = 1'b0;
	endtask

	// Keystream runs longer than data; data meets its tail
	task automatic burst(input logic u, input logic [11:0] n, k);
		start(u, n, k);
		for (int j = 0; j < k; j++)
		begin
			s_kv = 1'b1;
			s_kb = pat(3 * j + 1);
			s_v = j >= k - n;
			s_b = pat(j - k + n);
			tick;
		end
		{s_kv, s_v} = 2'h0;
		for (int j = 0; j < 60 && !seen[6]; j++)
			tick;
		chk("bits", n + 16, wq.size());
		chk("crc", 2'h1, seen[7:6]);
		for (int i = 0; i < n; i++)
		begin
			chk("cipher", pat(i) ^ pat(3*(i+k-n)+1), wq[i]);
			chk("plain", pat(i), rq[i]);
		end
	endtask

	task automatic t_caps;
		for (int i = 1; i < 4; i++)
		begin
			adv(4'h3, 5'(4 + i), 5'h03);
			go(1'b1, 6'(8 + 8 * i));
			chk("aes", {6'(8+8*i), 2'h0}, {b_kl, seen[1:0]});
			chk("akey", km(8 + 8 * i), t_key);
			go(1'b1, 6'(16 + 8 * i));
			chk("amax", 2'h3, seen[1:0]);
		end
		go(1'b1, 6'h14);
		chk("a20", 2'h3, seen[1:0]);
		go(1'b0, 6'h07);
		chk("sc", 3'h0, {b_ka, seen[1:0]});
		chk("key", km(7), b_key);
		chk("iv", {8{secret[287:256]^stream_iv}}, {b_iv, t_iv});
		go(1'b0, 6'h08);
		chk("sc8", 2'h3, seen[1:0]);
		adv(4'h2, 5'h07, 5'h00);
		go(1'b0, 6'h05);
		chk("sc0", 2'h3, seen[1:0]);
		adv(4'h3, 5'h0B, 5'h03);
		chk("mode", 2'h3, {b_ce, t_ce});
		adv(4'h3, 5'h07, 5'h03);
		chk("ok", 2'h0, {b_ce, t_ce});
	endtask

	task automatic t_lim;
		{brl, bbl, trl, tbl} = {16'h0002, 16'h0002, 16'h0002, 16'h0001};
		secret_load = 1'b1;
		tick;
		secret_load = 1'b0;
		go(1'b0, 6'h07);
		go(1'b0, 6'h07);
		chk("reg", 2'h3, seen[9:8]);
		start(1'b0, 12'h09EC, 12'h09EC);
		repeat (3) tick;
		chk("dlen", 2'h3, seen[3:2]);
		start(1'b1, 12'h03D9, 12'h03D9);
		repeat (3) tick;
		chk("ulen", 2'h3, seen[3:2]);
		burst(1'b1, 12'h03D8, 12'h03DE);
		chk("tclose", 2'h2, {seen[5], t_so});
		burst(1'b0, 12'h00A, 12'h00E);
		burst(1'b0, 12'h001, 12'h009);
		chk("bclose", 2'h2, {seen[4], b_so});
		go(1'b0, 6'h07);
		chk("full", 1'b1, seen[0]);
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		rst = 1'b1;
		{secret_load, stream_start, use_aes, up, s_start, s_v, s_b} = '0;
		{s_kv, s_kb, r_start, r_kv, r_kb, key_len_req, s_len, s_kl} = '0;
		{brl, bbl, trl, tbl} = '0;
		adv_alg = 4'h3;
		adv_par = {10'h000, 5'h07, 5'h03};
		secret = 326'({11{30'h2AC3_5F19}});
		stream_iv = 32'h1234_ABCD;
		seen = '0;
		repeat (4) @(posedge core_clk);
		#1 rst = 1'b0;
		tick;
		t_caps;
		t_lim;
		give_verdict;
	end
endmodule // tb_secure_link_key_iv_and_burst_xor
`default_nettype wire
